// ---- logic/sleep_wake_pkg.sv ----
// Constants, register map and state encoding for the sleep and wakeup controller
package sleep_wake_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;

  // Control word field positions
  localparam int unsigned CTRL_DEEP_BIT = 0;
  localparam int unsigned CTRL_EXIT_BIT = 1;
  localparam int unsigned CTRL_PEND_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // Status word field positions
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_DEEP_BIT = 4;
  localparam int unsigned STAT_CAUSE_LSB = 8;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Cycles the clock runs again before the core proceeds after a wakeup
  localparam int unsigned WAKE_CYCLES = 1;

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SLEEP_IRQ = 3'h1,
    ST_SLEEP_EVT = 3'h2,
    ST_WAKE = 3'h3,
    ST_LOCKUP = 3'h4
  } state_e;

  typedef enum logic [2:0] {
    CAUSE_NONE = 3'h0,
    CAUSE_EXC = 3'h1,
    CAUSE_EVENT = 3'h2,
    CAUSE_PEND = 3'h3,
    CAUSE_SPUR = 3'h4,
    CAUSE_NMI = 3'h5
  } cause_e;

endpackage

// ---- logic/sleep_wake_control.sv ----
// Sleep entry, event latch, wakeup decision and clock gating for the processor core
//
// Notes on behaviour
// - Light sleep gates only the core clock; other clocks keep running.
// - Deep sleep requests most system and peripheral clocks to stop.
// - Deep-sleep select bit chooses light or deep sleep on every entry.
// - Wait-for-interrupt stops issue and sleeps immediately, unless a nested hard fault in the same cycle locks up instead.
// - Wait-for-event with event latch clear stops issue and sleeps.
// - Wait-for-event with latch set clears it and continues without sleeping.
// - External event or any send-event instruction sets the event latch.
// - Software has no register path to read or write the event latch.
// - Sleep-after-handler set: returning to thread mode sleeps at once.
// - Sleep from wait-for-interrupt or after-handler wakes on enterable exceptions.
// - Global mask set, fault mask clear: enabled higher interrupt wakes, handler deferred.
// - Sleep from wait-for-event wakes on enterable exception or event input.
// - Pending-raises-event set: any newly pending interrupt makes an event while awake and wakes wait-for-event sleep only.
// - Event pulse while awake sets latch so next wait-for-event continues.
// - Spurious wakeups, such as debug, may occur; software re-enters sleep.
// - Lockup issues nothing until reset or a non-maskable interrupt.

`timescale 1ns/1ps

module sleep_wake_control #(
  parameter int unsigned WAKE_CYC = sleep_wake_pkg::WAKE_CYCLES
) (
  input wire logic core_clk, // Processor clock, 100 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  // AXI4-Lite slave
  input wire logic [sleep_wake_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [sleep_wake_pkg::DATA_W-1:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [sleep_wake_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [sleep_wake_pkg::DATA_W-1:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  // Pipeline side
  input wire logic wait_irq_instr, // Wait-for-interrupt executed, pulse
  input wire logic wait_event_instr, // Wait-for-event executed, pulse
  input wire logic send_event_instr, // Local send-event executed, pulse
  input wire logic handler_return_thread, // Handler completed, returning to thread
  input wire logic hard_fault_nested, // Hard fault in NMI or hard fault handler
  input wire logic global_irq_mask, // Core global interrupt mask
  input wire logic fault_level_mask, // Core fault-level mask
  output logic issue_stall, // Pipeline must not issue instructions
  output logic event_consumed, // Wait-for-event continued, latch cleared
  output logic core_clk_en, // Enable of the gated core clock
  output logic exc_entry_ok, // Exception entry may proceed now
  output logic lockup, // Core is locked up
  // Interrupt prioritisation side
  input wire logic irq_pri_ok, // Enabled exception above current priority
  input wire logic irq_new_pending, // An interrupt became pending, pulse
  input wire logic nmi_req, // Non-maskable interrupt request
  // System side
  input wire logic ext_event, // Event input from external event controller
  input wire logic remote_send_event, // Another processor sent an event
  input wire logic debug_wake, // Debug request wakes the core
  output logic deep_sleep, // Request to stop system clocks
  output logic wake_pulse // One-cycle pulse on every wakeup
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  sleep_wake_pkg::state_e state_q, state_d;
  sleep_wake_pkg::cause_e cause_q, cause_d;
  logic event_latch_q, event_latch_d;
  logic deep_q, deep_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [7:0] wake_cnt_q, wake_cnt_d;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [sleep_wake_pkg::DATA_W-1:0] rdata_q;
  logic aw_held_q, w_held_q;
  logic [sleep_wake_pkg::ADDR_W-1:0] awaddr_q;
  logic [sleep_wake_pkg::DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;

  wire ev_sync_q;
  logic ev_meta_q, ev_sync_r, ev_prev_q;
  logic rse_meta_q, rse_sync_q;
  logic dbg_meta_q, dbg_sync_q;

  wire deep_sel = ctrl_q[sleep_wake_pkg::CTRL_DEEP_BIT];
  wire exit_sel = ctrl_q[sleep_wake_pkg::CTRL_EXIT_BIT];
  wire pend_sel = ctrl_q[sleep_wake_pkg::CTRL_PEND_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Event input conditioning

  // Event pins come from another part of the chip; two stages before use
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_meta_q <= 1'b0;
      ev_sync_r <= 1'b0;
      ev_prev_q <= 1'b0;
      rse_meta_q <= 1'b0;
      rse_sync_q <= 1'b0;
      dbg_meta_q <= 1'b0;
      dbg_sync_q <= 1'b0;
    end else begin
      ev_meta_q <= ext_event;
      ev_sync_r <= ev_meta_q;
      ev_prev_q <= ev_sync_r;
      rse_meta_q <= remote_send_event;
      rse_sync_q <= rse_meta_q;
      dbg_meta_q <= debug_wake;
      dbg_sync_q <= dbg_meta_q;
    end
  end

  assign ev_sync_q = ev_sync_r;

  // Rising edge of the external event, counted once per assertion
  wire ev_rise = ev_sync_q & ~ev_prev_q;
  // Sources that mark an event for the latch in every state; pend_event is added only outside sleep
  wire ev_any = ev_rise | send_event_instr | rse_sync_q;
  wire pend_event = pend_sel & irq_new_pending;

  ////////////////////////////////////////////////////////////////////////////
  // Wakeup and entry decisions

  wire awake = (state_q == sleep_wake_pkg::ST_RUN);
  // Exception can be entered; a set fault-level mask blocks all but NMI
  wire exc_enterable = irq_pri_ok & ~global_irq_mask & ~fault_level_mask;
  // Wakes also when only the global mask holds the handler back
  wire exc_wakes = irq_pri_ok & ~fault_level_mask;
  wire wake_irq_path = exc_wakes | nmi_req;
  wire wake_evt_path = exc_wakes | nmi_req | ev_rise | pend_event;
  // Sleep request from the pipeline
  wire enter_wfi = awake & wait_irq_instr;
  wire enter_wfe = awake & wait_event_instr & ~event_latch_q;
  wire skip_wfe = awake & wait_event_instr & event_latch_q;
  wire enter_exit = awake & handler_return_thread & exit_sel;
  wire enter_irq = enter_wfi | enter_exit;
  wire in_sleep = (state_q == sleep_wake_pkg::ST_SLEEP_IRQ) |
                  (state_q == sleep_wake_pkg::ST_SLEEP_EVT);
  wire wake_now = ((state_q == sleep_wake_pkg::ST_SLEEP_IRQ) & (wake_irq_path | dbg_sync_q)) |
                  ((state_q == sleep_wake_pkg::ST_SLEEP_EVT) & (wake_evt_path | dbg_sync_q));

  ////////////////////////////////////////////////////////////////////////////
  // Sleep state machine

  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    deep_d = deep_q;
    wake_cnt_d = wake_cnt_q;
    unique case (state_q)
      sleep_wake_pkg::ST_RUN: begin
        wake_cnt_d = 8'h00;
        if (hard_fault_nested) begin
          state_d = sleep_wake_pkg::ST_LOCKUP;
        end else if (enter_irq) begin
          state_d = sleep_wake_pkg::ST_SLEEP_IRQ;
          deep_d = deep_sel;
        end else if (enter_wfe) begin
          state_d = sleep_wake_pkg::ST_SLEEP_EVT;
          deep_d = deep_sel;
        end
      end
      sleep_wake_pkg::ST_SLEEP_IRQ, sleep_wake_pkg::ST_SLEEP_EVT: begin
        if (wake_now) begin
          state_d = sleep_wake_pkg::ST_WAKE;
          deep_d = 1'b0;
          if (nmi_req) begin
            cause_d = sleep_wake_pkg::CAUSE_NMI;
          end else if (exc_wakes) begin
            cause_d = sleep_wake_pkg::CAUSE_EXC;
          end else if (state_q == sleep_wake_pkg::ST_SLEEP_EVT && ev_rise) begin
            cause_d = sleep_wake_pkg::CAUSE_EVENT;
          end else if (state_q == sleep_wake_pkg::ST_SLEEP_EVT && pend_event) begin
            cause_d = sleep_wake_pkg::CAUSE_PEND;
          end else begin
            cause_d = sleep_wake_pkg::CAUSE_SPUR;
          end
        end
      end
      sleep_wake_pkg::ST_WAKE: begin
        // Clock already running; hold issue until it has settled
        wake_cnt_d = wake_cnt_q + 8'h01;
        if (wake_cnt_q >= 8'(WAKE_CYC - 1)) begin
          state_d = sleep_wake_pkg::ST_RUN;
        end
      end
      sleep_wake_pkg::ST_LOCKUP: begin
        if (nmi_req) begin
          state_d = sleep_wake_pkg::ST_RUN;
          cause_d = sleep_wake_pkg::CAUSE_NMI;
        end
      end
      default: begin
        state_d = sleep_wake_pkg::ST_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event latch

  // Set beats clear when an event lands in the same cycle as a consuming wait-for-event.
  // Waking from event sleep by the event itself consumes it.
  always_comb begin
    event_latch_d = event_latch_q;
    if (skip_wfe) begin
      event_latch_d = 1'b0;
    end
    if (ev_any | (pend_event & ~in_sleep)) begin
      event_latch_d = 1'b1;
    end
    if (wake_now && state_q == sleep_wake_pkg::ST_SLEEP_EVT) begin
      event_latch_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= sleep_wake_pkg::ST_RUN;
      cause_q <= sleep_wake_pkg::CAUSE_NONE;
      event_latch_q <= 1'b0;
      deep_q <= 1'b0;
      wake_cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      event_latch_q <= event_latch_d;
      deep_q <= deep_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core-facing outputs

  // Only the core clock is gated in either sleep; deep also asks system clocks
  assign core_clk_en = ~in_sleep;
  assign deep_sleep = in_sleep & deep_q;
  assign issue_stall = ~awake | enter_irq | enter_wfe;
  assign event_consumed = skip_wfe;
  assign lockup = (state_q == sleep_wake_pkg::ST_LOCKUP);
  // Deferred while the global mask holds; exceptions wait for the clock
  assign exc_entry_ok = awake & exc_enterable;
  assign wake_pulse = (state_q == sleep_wake_pkg::ST_WAKE) & (wake_cnt_q == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register slave

  // Address and data are taken independently; the write commits once both are in
  wire aw_take = s_axi_awvalid & ~aw_held_q & ~bvalid_q;
  wire w_take = s_axi_wvalid & ~w_held_q & ~bvalid_q;
  wire wr_go = (aw_held_q | aw_take) & (w_held_q | w_take);
  wire [sleep_wake_pkg::ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [sleep_wake_pkg::DATA_W-1:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire rd_go = s_axi_arvalid & ~rvalid_q;
  wire wr_ctrl = wr_go & (wr_addr == sleep_wake_pkg::CTRL_OFS);
  wire wr_stat = wr_go & (wr_addr == sleep_wake_pkg::STAT_OFS);
  wire rd_ctrl = (s_axi_araddr == sleep_wake_pkg::CTRL_OFS);
  wire rd_stat = (s_axi_araddr == sleep_wake_pkg::STAT_OFS);

  assign s_axi_awready = aw_take;
  assign s_axi_wready = w_take;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Event latch deliberately absent from both words
  wire [sleep_wake_pkg::DATA_W-1:0] ctrl_word = {29'h0, ctrl_q};
  wire [sleep_wake_pkg::DATA_W-1:0] stat_word = {
    21'h0, cause_q, 3'h0, deep_sleep, 1'b0, state_q};

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl && wr_strb[0]) begin
      ctrl_d = wr_data[2:0];
    end
  end

  // Half of a write waits here until its partner arrives
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end else begin
      aw_held_q <= (aw_held_q | aw_take) & ~wr_go;
      w_held_q <= (w_held_q | w_take) & ~wr_go;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= sleep_wake_pkg::CTRL_RST;
      bvalid_q <= 1'b0;
      bresp_q <= sleep_wake_pkg::RESP_OKAY;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_ctrl | wr_stat) ? sleep_wake_pkg::RESP_OKAY :
                   sleep_wake_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rresp_q <= sleep_wake_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else begin
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q <= (rd_ctrl | rd_stat) ? sleep_wake_pkg::RESP_OKAY :
                   sleep_wake_pkg::RESP_SLVERR;
        rdata_q <= rd_ctrl ? ctrl_word : (rd_stat ? stat_word : '0);
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule

// ---- testbench/sleep_wake_control_monitor.sv ----
// Checker of sleep entry, wakeup and clock gating at the block ports
`timescale 1ns/1ps
module sleep_wake_control_monitor (
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic wait_irq_instr, // Wait-for-interrupt pulse
  input wire logic wait_event_instr, // Wait-for-event pulse
  input wire logic handler_return_thread, // Handler return
  input wire logic hard_fault_nested, // Nested fault
  input wire logic global_irq_mask, // Global mask
  input wire logic fault_level_mask, // Fault mask
  input wire logic issue_stall, // No issue
  input wire logic event_consumed, // Wait-for-event continued
  input wire logic core_clk_en, // Clock enable
  input wire logic exc_entry_ok, // Entry allowed
  input wire logic lockup, // Locked up
  input wire logic irq_pri_ok, // Irq above priority
  input wire logic nmi_req, // Nmi
  input wire logic ext_event, // Event input
  input wire logic deep_sleep, // Deep request
  input wire logic wake_pulse // Wakeup
);
  logic stall_q;
  logic evt_q;
  wire run_ok = core_clk_en && !lockup && !stall_q;
  wire any_entry = wait_irq_instr || wait_event_instr || handler_return_thread;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stall_q <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      stall_q <= issue_stall;
      if (run_ok && any_entry) begin
        evt_q <= wait_event_instr && !wait_irq_instr;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_wfi_sleep;
    run_ok && wait_irq_instr && !hard_fault_nested |-> issue_stall ##1 !core_clk_en;
  endproperty
  a_wfi_sleep: assert property (p_wfi_sleep)
    else $error("wait for interrupt did not sleep");
  property p_wfe_sleep;
    run_ok && wait_event_instr && !wait_irq_instr && !event_consumed && !hard_fault_nested
      |-> issue_stall ##1 !core_clk_en;
  endproperty
  a_wfe_sleep: assert property (p_wfe_sleep)
    else $error("wait for event did not sleep");
  property p_wfe_go;
    event_consumed |-> wait_event_instr && !issue_stall ##1 core_clk_en;
  endproperty
  a_wfe_go: assert property (p_wfe_go)
    else $error("wait for event with latch set slept");
  property p_deep;
    deep_sleep |-> !core_clk_en;
  endproperty
  a_deep: assert property (p_deep)
    else $error("deep request while awake");
  property p_wake_clk;
    $rose(core_clk_en) |-> wake_pulse && issue_stall ##1 !wake_pulse && core_clk_en;
  endproperty
  a_wake_clk: assert property (p_wake_clk)
    else $error("clock not back before resume");
  property p_irq_wake;
    !core_clk_en && (irq_pri_ok && !fault_level_mask || nmi_req) |=> wake_pulse;
  endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("exception did not wake");
  property p_exc_ok;
    exc_entry_ok |-> irq_pri_ok && !global_irq_mask && !fault_level_mask && core_clk_en;
  endproperty
  a_exc_ok: assert property (p_exc_ok)
    else $error("handler entry while masked");
  property p_exc_go;
    irq_pri_ok && !global_irq_mask && !fault_level_mask && !issue_stall |-> exc_entry_ok;
  endproperty
  a_exc_go: assert property (p_exc_go)
    else $error("handler entry withheld while unmasked");
  property p_lock;
    lockup && !nmi_req |=> lockup && issue_stall;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lockup left without nmi");
  property p_evt_wake;
    evt_q && !core_clk_en && $rose(ext_event) |-> ##[1:5] wake_pulse;
  endproperty
  a_evt_wake: assert property (p_evt_wake)
    else $error("event did not wake");
endmodule

bind sleep_wake_control sleep_wake_control_monitor u_sleep_wake_control_monitor (.*);

// ---- testbench/event_irq_model.sv ----
// Model of the event controller and interrupt priority logic
`timescale 1ns/1ps
module event_irq_model (
  input wire logic core_clk, // Clock
  input wire logic fire, // Start one source
  input wire logic [1:0] src, // 0 event 1 irq 2 pend 3 nmi
  input wire logic [2:0] dly, // Cycles before raising
  output logic ext_event, // Event input
  output logic irq_pri_ok, // Irq above priority
  output logic irq_new_pending, // New pending pulse
  output logic nmi_req // Nmi request
);
  logic [3:0] wait_cnt = '0;
  logic [3:0] hold_cnt = '0;
  logic [1:0] kind = '0;
  always @(posedge core_clk) begin
    if (fire) begin
      kind <= src;
      wait_cnt <= 4'(dly) + 4'h1;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
      hold_cnt <= (wait_cnt == 4'h1) ? 4'h8 : 4'h0;
    end else if (hold_cnt != 4'h0) begin
      hold_cnt <= hold_cnt - 4'h1;
    end
  end
  // Event line is a 3 cycle pulse so the synchroniser sees it
  assign ext_event = kind == 2'h0 && hold_cnt > 4'h5;
  assign irq_pri_ok = kind == 2'h1 && hold_cnt != 4'h0;
  assign irq_new_pending = kind == 2'h2 && hold_cnt == 4'h8;
  assign nmi_req = kind == 2'h3 && hold_cnt != 4'h0;
endmodule

// ---- testbench/sleep_wake_control_bench.sv ----
// Self-checking bench of the sleep and wakeup controller
`timescale 1ns/1ps
module sleep_wake_control_bench;
  logic core_clk = 0;
  logic sys_rst = 1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, src = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic wait_irq_instr = 0, wait_event_instr = 0, send_event_instr = 0, hard_fault_nested = 0;
  logic handler_return_thread = 0, global_irq_mask = 0, fault_level_mask = 0, fire = 0;
  logic remote_send_event = 0, debug_wake = 0, st, ev;
  logic issue_stall, event_consumed, core_clk_en, exc_entry_ok, lockup, irq_pri_ok;
  logic irq_new_pending, nmi_req, ext_event, deep_sleep, wake_pulse;
  logic [2:0] dly = '0;
  logic [7:0] seed = 8'h39;
  int num_errors = 0;
  int comparisons = 0;
  int rows [7][3] = '{'{0, 0, 1}, '{1, 0, 1}, '{0, 1, 0}, '{4, 1, 2}, '{2, 2, 1}, '{0, 0, 4},
    '{1, 1, 3}};
  sleep_wake_control #(.WAKE_CYC(1)) u_sleep_wake_control (.*);
  event_irq_model u_event_irq_model (.*);
  ////////////////////////////////////////////////////////////////////////////////
  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function logic [2:0] cause_of(input int s);
    case (s)
      0: return sleep_wake_pkg::CAUSE_EVENT;
      1: return sleep_wake_pkg::CAUSE_EXC;
      2: return sleep_wake_pkg::CAUSE_PEND;
      3: return sleep_wake_pkg::CAUSE_NMI;
      default: return sleep_wake_pkg::CAUSE_SPUR;
    endcase
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do @(negedge core_clk); while (!(s_axi_awready && s_axi_wready));
    @(posedge core_clk);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    do @(negedge core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge core_clk);
    s_axi_bready <= 0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(negedge core_clk); while (!s_axi_arready);
    @(posedge core_clk);
    s_axi_arvalid <= 0;
    do @(negedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge core_clk);
    s_axi_rready <= 0;
  endtask
  // Kinds: 0 wait-irq, 1 wait-event, 2 handler return, 3 send event, 4 nested fault
  task pulse(input int k);
    @(posedge core_clk);
    {hard_fault_nested, send_event_instr, handler_return_thread, wait_event_instr,
      wait_irq_instr} <= 5'h1 << k;
    @(negedge core_clk);
    st = issue_stall;
    ev = event_consumed;
    @(posedge core_clk);
    {hard_fault_nested, send_event_instr, handler_return_thread, wait_event_instr,
      wait_irq_instr} <= 5'h0;
  endtask
  task raise(input int s);
    seed = lfsr(seed);
    @(posedge core_clk);
    fire <= 1;
    src <= 2'(s);
    dly <= seed[2:0];
    @(posedge core_clk);
    fire <= 0;
  endtask
  task wait_wake;
    for (int i = 0; i < 24 && wake_pulse !== 1'b1; i++) begin
      @(negedge core_clk);
    end
    chk({wake_pulse, core_clk_en}, 2'b11, "no wakeup");
  endtask
  task sleep_case(input logic [2:0] ctrl, input int how, input int s);
    wr(sleep_wake_pkg::CTRL_OFS, {29'h0, ctrl});
    global_irq_mask <= (how == 2);
    pulse(how);
    chk(st, 1, "issue not stopped");
    @(negedge core_clk);
    chk({core_clk_en, deep_sleep}, {1'b0, ctrl[0]}, "sleep kind");
    if (s == 4) begin
      @(posedge core_clk);
      debug_wake <= 1;
    end else begin
      raise(s);
    end
    wait_wake;
    @(posedge core_clk);
    debug_wake <= 0;
    if (how == 2) begin
      @(negedge core_clk);
      chk(exc_entry_ok, 0, "handler not deferred");
      @(posedge core_clk);
      global_irq_mask <= 0;
      @(negedge core_clk);
      chk(exc_entry_ok, 1, "handler still held");
    end
    rd(sleep_wake_pkg::STAT_OFS);
    chk(d[10:8], cause_of(s), "wake cause");
    repeat (12) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("wrong value at %0t: timeout", $time);
    finish_test;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 0;
    rd(sleep_wake_pkg::CTRL_OFS);
    chk(d, 0, "control reset");
    seed = lfsr(seed);
    wr(sleep_wake_pkg::CTRL_OFS, {seed, seed, seed, seed});
    rd(sleep_wake_pkg::CTRL_OFS);
    chk(d, {29'h0, seed[2:0]}, "control readback");
    wr(sleep_wake_pkg::STAT_OFS, {24'h0, seed});
    chk(r, sleep_wake_pkg::RESP_OKAY, "status write");
    rd(12'h008);
    chk({r, d}, {sleep_wake_pkg::RESP_SLVERR, 32'h0}, "unmapped read");
    wr(12'h00c, 32'hffffffff);
    chk(r, sleep_wake_pkg::RESP_SLVERR, "unmapped write");
    $display("test registers done");
    foreach (rows[i]) sleep_case(3'(rows[i][0]), rows[i][1], rows[i][2]);
    $display("test sleep and wake done");
    for (int k = 0; k < 3; k++) begin
      if (k == 0) pulse(3);
      if (k == 1) raise(0);
      if (k == 2) remote_send_event <= 1;
      repeat (16) @(posedge core_clk);
      remote_send_event <= 0;
      repeat (4) @(posedge core_clk);
      pulse(1);
      chk({st, ev}, 2'b01, "wait-event with latch set");
    end
    pulse(1);
    chk(st, 1, "latch not cleared");
    raise(0);
    wait_wake;
    @(posedge core_clk);
    fault_level_mask <= 1;
    pulse(0);
    raise(1);
    repeat (10) @(negedge core_clk);
    chk(core_clk_en, 0, "woke under fault mask");
    raise(3);
    wait_wake;
    repeat (20) @(posedge core_clk);
    fault_level_mask <= 0;
    $display("test event latch done");
    pulse(4);
    pulse(0);
    @(negedge core_clk);
    chk({lockup, issue_stall, core_clk_en}, 3'b111, "lockup state");
    raise(3);
    repeat (14) @(negedge core_clk);
    chk(lockup, 0, "lockup stuck");
    $display("test lockup done");
    finish_test;
  end
endmodule
